// file: logic/data_eeprom_write_controller.sv
// Summary of operation
// RL1: The block holds a 256 by 8-bit nonvolatile array mapped in data space.
// RL2: The CPU reads and writes the array with plain byte loads and stores.
// RL3: Programming runs in the background so other accesses proceed.
// RL4: Each completed write pulses the write-done interrupt request.
// RL5: The busy state reads back at bit 1 of the control register.
// RL6: The control register takes bit and byte writes and resets to zero.
// RL7: Bits 7,6,3 read zero, 5:4 time select, 2 stop, 1 busy, 0 enable.
// RL8: Select 00 gives 2^14+2^10 periods and 01 gives 2^15+2^11 periods.
// RL9: Stop control zero means operating and one stops the array.
// RL10: Busy is one while writing with array access barred, else zero.
// RL11: With write enable clear, stores to the array are ignored.
// RL12: Clearing write enable during a write aborts it at once.
// RL13: A store arriving while busy is dropped and the write carries on.
// RL14: An accepted store latches address and data, sets busy and times out.
// RL15: Writes to fixed-zero bits and to busy have no effect.
`timescale 1ns/1ps
`default_nettype none

module data_eeprom_write_controller
  import nv_data_pkg::*;
#(
  parameter logic [15:0] BASE = NV_BASE,
  parameter int DEPTH = NV_DEPTH,
  parameter int SHORT_CYC = WT_SHORT_CYC,
  parameter int LONG_CYC = WT_LONG_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // CPU data access
  input wire cpu_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_hit,
  // Status and events
  output logic o_write_busy_flag,
  output logic o_array_stopped,
  output logic o_write_done_irq
);

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rdata;
    logic hit;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    prog_state_t st;
  } ctl_state_t;

  ctl_state_t q, d;
  logic [7:0] mem [DEPTH];
  logic done;
  logic start;
  logic abort;
  // Address decode
  logic ctl_sel;
  logic arr_sel;
  logic [7:0] arr_idx;
  // Qualified accesses
  logic ctl_wr;
  logic ctl_rd;
  logic arr_wr;
  logic arr_rd;
  // Array gating
  logic arr_open;
  logic wr_ok;
  logic kill;
  // Data paths
  logic [7:0] ctl_new;
  logic [7:0] arr_q;
  logic [7:0] rd_data;
  logic mem_wr;
  logic [7:0] mem_wdata;

  assign ctl_sel = (i_req.addr == CTL_ADDR);
  assign arr_sel = (i_req.addr >= BASE) &&
                   ({16'h0000, i_req.addr} < {16'h0000, BASE} + 32'(DEPTH));
  assign arr_idx = 8'(i_req.addr - BASE);

  assign ctl_wr = i_req.wr && ctl_sel;
  assign ctl_rd = i_req.rd && ctl_sel;
  assign arr_wr = i_req.wr && arr_sel;
  assign arr_rd = i_req.rd && arr_sel;

  // The array answers only while idle and not stopped
  assign arr_open = (q.st == ST_IDLE) && !q.ctl[BIT_STOP]; // RL10 RL9
  // A store starts programming only with write enable set as well
  assign wr_ok = arr_wr && arr_open && q.ctl[BIT_WEN]; // RL11
  // Write enable dropped by a control write, bit or byte form
  assign kill = ctl_wr && !ctl_new[BIT_WEN]; // RL12
  // Combinational array read keeps the read answer at one cycle
  assign arr_q = mem[arr_idx];

  // Read return path; refused and unmapped reads answer zero
  always_comb begin
    rd_data = 8'h00;
    case (1'b1)
      ctl_rd: begin
        rd_data = q.ctl; // RL5
      end
      arr_rd: begin
        if (arr_open) begin
          rd_data = arr_q; // RL2
        end
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // Bit and byte forms of the control write merge through one mask
  always_comb begin
    ctl_new = q.ctl;
    if (i_req.bit_op) begin
      ctl_new[i_req.bit_idx] = i_req.bit_val; // RL6
    end else begin
      ctl_new = i_req.wdata;
    end
    ctl_new = (ctl_new & CTL_WMASK) | (q.ctl & ~CTL_WMASK); // RL15 RL7
  end

  always_comb begin
    d = q;
    start = 1'b0;
    abort = 1'b0;
    d.hit = ctl_rd || arr_rd; // RL2
    d.rdata = rd_data;
    if (ctl_wr) begin
      d.ctl = ctl_new; // RL6
    end
    case (q.st)
      ST_IDLE: begin
        if (wr_ok) begin
          start = 1'b1;
          d.wr_addr = arr_idx; // RL14
          d.wr_data = i_req.wdata;
          d.ctl[BIT_BUSY] = 1'b1;
          d.st = ST_PROG;
        end
      end
      // Stores are not looked at here, so a busy store is dropped
      ST_PROG: begin // RL13
        // Completion wins a same-cycle abort; the byte is written on that same edge
        if (done) begin
          d.ctl[BIT_BUSY] = 1'b0; // RL14
          d.st = ST_IDLE;
        end else if (kill) begin
          abort = 1'b1; // RL12
          d.ctl[BIT_BUSY] = 1'b0;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  // Array write events
  always_comb begin
    mem_wr = 1'b0;
    mem_wdata = q.wr_data;
    if (q.st == ST_PROG && done) begin
      mem_wr = 1'b1; // RL1
    end else if (abort) begin
      mem_wr = 1'b1;
      // An aborted byte is left holding garbage: inverted data
      mem_wdata = ~q.wr_data; // RL12
    end
  end

  // No reset on the array: its contents must survive a reset
  always_ff @(posedge i_core_clk) begin
    if (mem_wr) begin
      mem[q.wr_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
      q.ctl <= CTL_RESET; // RL6
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // Select is taken at the start; later changes do not stretch a write
  nv_write_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_start(start),
    .i_abort(abort),
    .i_tsel(q.ctl[BIT_TSEL_HI:BIT_TSEL_LO]), // RL8
    .o_done(done)
  );

  assign o_rdata = q.rdata;
  assign o_hit = q.hit;
  assign o_write_busy_flag = q.ctl[BIT_BUSY]; // RL3
  assign o_array_stopped = q.ctl[BIT_STOP];
  // Gated by state so no stray pulse can follow an abort
  assign o_write_done_irq = done && (q.st == ST_PROG); // RL4

endmodule

`default_nettype wire

// file: logic/nv_data_pkg.sv
`default_nettype none
package nv_data_pkg;

  // Control register location in the data space
  localparam logic [15:0] CTL_ADDR = 16'hff90;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Control register field positions
  localparam int BIT_WEN = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_STOP = 2;
  localparam int BIT_TSEL_LO = 4;
  localparam int BIT_TSEL_HI = 5;
  // Bits that software may change; 7, 6, 3 and busy stay fixed
  localparam logic [7:0] CTL_WMASK = 8'h35;

  // Array size and default window in data space
  localparam int NV_DEPTH = 256;
  localparam logic [15:0] NV_BASE = 16'hf800;

  // Write times in main clock periods
  localparam int WT_SHORT_CYC = (1 << 14) + (1 << 10);
  localparam int WT_LONG_CYC = (1 << 15) + (1 << 11);
  localparam int WT_CNT_W = 16;

  // Write-time select codes
  localparam logic [1:0] TSEL_SHORT = 2'h0;
  localparam logic [1:0] TSEL_LONG = 2'h1;

  // One CPU access, as the core presents it
  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_op;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } prog_state_t;

endpackage
`default_nettype wire

// file: logic/nv_write_timer.sv
`timescale 1ns/1ps
`default_nettype none

module nv_write_timer
  import nv_data_pkg::*;
#(
  parameter int SHORT_CYC = WT_SHORT_CYC,
  parameter int LONG_CYC = WT_LONG_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [1:0] i_tsel,
  // Status
  output logic o_done
);

  typedef struct packed {
    logic [WT_CNT_W-1:0] cnt;
    logic run;
    logic done;
  } tmr_t;

  tmr_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (i_start) begin
      d.run = 1'b1;
      // Load count minus one so the pulse lands on the last period
      if (i_tsel == TSEL_LONG) begin
        d.cnt = WT_CNT_W'(LONG_CYC - 1);
      end else begin
        d.cnt = WT_CNT_W'(SHORT_CYC - 1);
      end
    end else if (i_abort) begin
      d.run = 1'b0;
    end else if (q.run) begin
      if (q.cnt == '0) begin
        d.run = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - WT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_done = q.done;

endmodule

`default_nettype wire

// file: verification/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
  import nv_data_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Access
  input wire logic [7:0] i_rdata,
  output var cpu_req_t o_req
);
  initial o_req = '0;
  // Lines released by wr and rd show inverted values so stale data never looks valid; bw releases to zero
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_req <= '{wr: 1'b1, addr: a, wdata: d, default: '0};
    @(posedge i_core_clk);
    o_req <= '{addr: ~a, wdata: ~d, default: '0};
  endtask
  task automatic bw(input logic [2:0] i, input logic v);
    @(posedge i_core_clk);
    o_req <= '{wr: 1'b1, bit_op: 1'b1, bit_idx: i, bit_val: v,
      addr: CTL_ADDR, default: '0};
    @(posedge i_core_clk);
    o_req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_req <= '{rd: 1'b1, addr: a, default: '0};
    @(posedge i_core_clk);
    o_req <= '{addr: ~a, default: '0};
    #1 d = i_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/data_eeprom_write_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_write_controller_tb;
  import nv_data_pkg::*;
  localparam int SC = 20;
  localparam int LC = 40;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cpu_req_t req;
  logic [7:0] rdata, d;
  logic hit, busy, stopped, irq;
  int miscompares = 0;
  int cmp_count = 0;
  time t0;
  always #5 clk = ~clk;
  cpu_core_model u_cpu (.i_core_clk(clk), .i_rdata(rdata), .o_req(req));
  data_eeprom_write_controller #(.SHORT_CYC(SC), .LONG_CYC(LC)) u_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_req(req), .o_rdata(rdata),
    .o_hit(hit), .o_write_busy_flag(busy), .o_array_stopped(stopped),
    .o_write_done_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for the done pulse
  task automatic wt;
    for (int c = 0; c < 100 && irq !== 1'b1; c++) begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    u_cpu.rd(CTL_ADDR, d);
    chk(d, CTL_RESET);
    chk(hit, 1'b1);
    u_cpu.rd(16'hff91, d);
    chk(d, 8'h00);
    chk(hit, 1'b0);
    u_cpu.wr(CTL_ADDR, 8'hcf);
    u_cpu.rd(CTL_ADDR, d);
    chk(d, 8'h05);
    chk(stopped, 1'b1);
    u_cpu.wr(NV_BASE + 16'h9, 8'h77);
    u_cpu.rd(NV_BASE + 16'h9, d);
    chk(d, 8'h00);
    u_cpu.wr(CTL_ADDR, 8'h00);
    u_cpu.wr(NV_BASE + 16'h9, 8'h77);
    u_cpu.rd(CTL_ADDR, d);
    chk(d, 8'h00);
    $display("test 1 done");
    for (int t = 0; t < 2; t++) begin
      u_cpu.wr(CTL_ADDR, t ? 8'h11 : 8'h01);
      u_cpu.wr(NV_BASE + 16'(t), 8'h5a ^ 8'(t));
      t0 = $time;
      u_cpu.rd(NV_BASE + 16'(t), d);
      chk(d, 8'h00);
      u_cpu.wr(NV_BASE + 16'(t), 8'h33);
      u_cpu.rd(CTL_ADDR, d);
      chk(d, t ? 8'h13 : 8'h03);
      chk(busy, 1'b1);
      wt();
      chk(32'(($time - t0 - 1) / 10), t ? LC : SC);
      u_cpu.rd(NV_BASE + 16'(t), d);
      chk(d, 8'h5a ^ 8'(t));
      chk(busy, 1'b0);
    end
    $display("test 2 done");
    u_cpu.wr(CTL_ADDR, 8'h01);
    u_cpu.wr(NV_BASE + 16'h3, 8'h3c);
    u_cpu.bw(3'h0, 1'b0);
    u_cpu.rd(CTL_ADDR, d);
    chk(d, 8'h00);
    wt();
    chk(irq, 1'b0);
    u_cpu.rd(NV_BASE + 16'h3, d);
    chk(d, 8'hc3);
    $display("test 3 done");
    u_cpu.wr(CTL_ADDR, 8'h15);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    u_cpu.rd(CTL_ADDR, d);
    chk(d, CTL_RESET);
    chk(stopped, 1'b0);
    $display("test 4 done");
    end_sim();
  end
  // A few hundred cycles are needed; this leaves wide margin
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: verification/nv_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module nv_chk
  import nv_data_pkg::*;
#(
  parameter logic [15:0] BASE = NV_BASE,
  parameter int DEPTH = NV_DEPTH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire cpu_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_hit,
  input wire logic o_write_busy_flag,
  input wire logic o_array_stopped,
  input wire logic o_write_done_irq
);
  logic arr, ctl, bsy, irq, stp, go;
  assign arr = i_req.addr >= BASE && 32'(i_req.addr) < BASE + DEPTH;
  assign ctl = i_req.addr == CTL_ADDR;
  assign bsy = o_write_busy_flag;
  assign irq = o_write_done_irq;
  assign stp = o_array_stopped;
  assign go = i_req.wr && arr && !stp;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  AST_IRQ_END: assert property (irq |-> bsy ##1 !bsy && !irq)
    else $error("done pulse not ending a write");
  AST_HIT: assert property (o_hit |-> $past(i_req.rd))
    else $error("hit without read");
  AST_CTL_RD: assert property (i_req.rd && ctl |=> o_hit &&
    (o_rdata & 8'hc8) == 8'h00 && o_rdata[1] == $past(bsy) &&
    o_rdata[2] == $past(stp)) else $error("control readback wrong");
  AST_BUSY_RD: assert property (i_req.rd && arr && bsy |=>
    o_rdata == 8'h00) else $error("array read while busy");
  AST_STOP_RD: assert property (i_req.rd && arr && stp |=>
    o_rdata == 8'h00) else $error("array read while stopped");
  AST_RISE: assert property ($rose(bsy) |-> $past(go))
    else $error("busy without store");
  AST_DROP: assert property (i_req.wr && arr && bsy && !irq |=>
    bsy) else $error("store while busy disturbed write");
  AST_STOP_WR: assert property (i_req.wr && arr && stp && !bsy |=>
    !bsy) else $error("store while stopped started");
endmodule
bind data_eeprom_write_controller nv_chk #(.BASE(BASE), .DEPTH(DEPTH))
  u_chk (.*);
`default_nettype wire
